// [common/svc_pkg.sv]
package svc_pkg;
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_RESET_SEL = 8'h04;
  localparam logic [7:0] OFS_CAP_PCT = 8'h08;
  localparam logic [7:0] OFS_FAN_PCT = 8'h0c;
  localparam logic [7:0] OFS_NOTE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int MODE_W = 2;
  localparam int CAP_MODE_LSB = 0;
  localparam int FAN_MODE_LSB = 4;
  localparam int ST_CAP_EXP = 0;
  localparam int ST_FAN_EXP = 1;
  localparam int ST_CAP_WARN = 2;
  localparam int ST_FAN_WARN = 3;

  // ----------------------------------------
  // expiry handling modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_NOTE = 2'h1,
    MODE_ALARM = 2'h2,
    MODE_SPARE = 2'h3
  } svc_mode_t;
  localparam svc_mode_t MODE_RESET = MODE_NOTE;

  // ----------------------------------------
  // reset selector and notice codes
  // ----------------------------------------
  localparam logic [31:0] SEL_NONE = 32'h0000_0000;
  localparam logic [31:0] SEL_CAP = 32'h0000_0001;
  localparam logic [31:0] SEL_FAN = 32'h0000_0002;
  localparam int NOTE_W = 16;
  localparam logic [15:0] NOTE_NONE = 16'h0000;
  localparam logic [15:0] NOTE_CAP = 16'h0001;
  localparam logic [15:0] NOTE_FAN = 16'h0002;

  // ----------------------------------------
  // percentage
  // ----------------------------------------
  localparam int PCT_W = 7;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_EMPTY = 7'h00;
  localparam logic [6:0] PCT_STEP = 7'h01;
endpackage : svc_pkg

// [common/wear_if.sv]
`timescale 1ns/1ps
interface wear_if #(
  parameter int INC_W = 8
);
  logic [INC_W-1:0] wear_inc;
  logic age_en;
  logic restore;
  logic [svc_pkg::PCT_W-1:0] percent;
  logic expired;

  modport tracker (
    input wear_inc,
    input age_en,
    input restore,
    output percent,
    output expired
  );

  modport owner (
    output wear_inc,
    output age_en,
    output restore,
    input percent,
    input expired
  );
endinterface : wear_if

// [core/wear_tracker.sv]
`timescale 1ns/1ps
module wear_tracker #(
  parameter int INC_W = 8,
  parameter int ACC_W = 24,
  parameter int WEAR_PER_PCT = 1000000
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  wear_if.tracker w
);
  localparam logic [ACC_W:0] STEP = (ACC_W+1)'(WEAR_PER_PCT);

  logic [ACC_W-1:0] acc_reg;
  logic [svc_pkg::PCT_W-1:0] pct_reg;
  logic [ACC_W:0] sum;
  logic step_due;

  assign sum = {1'h0, acc_reg} + (ACC_W+1)'(w.wear_inc);
  assign step_due = sum >= STEP;
  assign w.percent = pct_reg;
  assign w.expired = pct_reg == svc_pkg::PCT_EMPTY;

  // ----------------------------------------
  // wear accumulator
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_reg <= '0;
    end else if (ce_in) begin
      if (w.restore) begin
        acc_reg <= '0;
      end else if (w.age_en && !w.expired) begin
        acc_reg <= step_due ? ACC_W'(sum - STEP) : ACC_W'(sum);
      end
    end
  end

  // ----------------------------------------
  // remaining percentage
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pct_reg <= svc_pkg::PCT_FULL;
    end else if (ce_in) begin
      if (w.restore) begin
        pct_reg <= svc_pkg::PCT_FULL;
      end else if (w.age_en && !w.expired && step_due) begin
        // saturates: aging stops once empty
        pct_reg <= pct_reg - svc_pkg::PCT_STEP;
      end
    end
  end
endmodule : wear_tracker

// [core/service_interval_monitor.sv]
`timescale 1ns/1ps
module service_interval_monitor #(
  parameter int TEMP_W = 8,
  parameter int SPEED_W = 8,
  parameter int ACC_W = 24,
  parameter int CAP_WEAR_PER_PCT = 1000000,
  parameter int FAN_WEAR_PER_PCT = 1000000
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [TEMP_W-1:0] cap_temp_in,
  input wire logic inverter_running_in,
  input wire logic [SPEED_W-1:0] fan_speed_in,
  input wire logic fan_running_in,
  output logic capacitor_expiry_warning_out,
  output logic fan_expiry_warning_out,
  output logic warning_msg_out,
  output logic panel_warning_out,
  output logic [15:0] maintenance_note_out
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic notice_on(input svc_pkg::svc_mode_t m);
    notice_on = (m == svc_pkg::MODE_NOTE) || (m == svc_pkg::MODE_ALARM);
  endfunction : notice_on

  function automatic logic alarm_on(input svc_pkg::svc_mode_t m);
    alarm_on = m == svc_pkg::MODE_ALARM;
  endfunction : alarm_on

  svc_pkg::svc_mode_t cap_mode_reg;
  svc_pkg::svc_mode_t fan_mode_reg;
  logic [31:0] rdata_reg;
  logic cap_warn_reg;
  logic fan_warn_reg;
  logic msg_reg;
  logic panel_reg;
  logic [15:0] note_reg;
  logic [15:0] note_next;
  logic sel_write;
  logic cap_warn_next;
  logic fan_warn_next;

  wear_if #(.INC_W(TEMP_W)) cap_w ();
  wear_if #(.INC_W(SPEED_W)) fan_w ();

  assign sel_write = wr_in && addr_in == svc_pkg::OFS_RESET_SEL;

  // ----------------------------------------
  // capacitor tracker
  // ----------------------------------------
  // temperature drives wear
  assign cap_w.wear_inc = cap_temp_in;
  assign cap_w.age_en = inverter_running_in;
  assign cap_w.restore = sel_write && wdata_in == svc_pkg::SEL_CAP;

  wear_tracker #(
    .INC_W(TEMP_W),
    .ACC_W(ACC_W),
    .WEAR_PER_PCT(CAP_WEAR_PER_PCT)
  ) u_cap (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .w(cap_w.tracker)
  );

  // ----------------------------------------
  // fan tracker
  // ----------------------------------------
  // speed per running cycle
  assign fan_w.wear_inc = fan_speed_in;
  assign fan_w.age_en = fan_running_in;
  assign fan_w.restore = sel_write && wdata_in == svc_pkg::SEL_FAN;

  wear_tracker #(
    .INC_W(SPEED_W),
    .ACC_W(ACC_W),
    .WEAR_PER_PCT(FAN_WEAR_PER_PCT)
  ) u_fan (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .w(fan_w.tracker)
  );

  // ----------------------------------------
  // mode register
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cap_mode_reg <= svc_pkg::MODE_RESET;
      fan_mode_reg <= svc_pkg::MODE_RESET;
    end else if (ce_in && wr_in && addr_in == svc_pkg::OFS_MODE) begin
      cap_mode_reg <= svc_pkg::svc_mode_t'(wdata_in[svc_pkg::CAP_MODE_LSB +: svc_pkg::MODE_W]);
      fan_mode_reg <= svc_pkg::svc_mode_t'(wdata_in[svc_pkg::FAN_MODE_LSB +: svc_pkg::MODE_W]);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= svc_pkg::RDATA_IDLE;
    end else if (ce_in) begin
      rdata_reg <= svc_pkg::RDATA_IDLE;
      if (rd_in) begin
        case (addr_in)
          svc_pkg::OFS_MODE: begin
            rdata_reg[svc_pkg::CAP_MODE_LSB +: svc_pkg::MODE_W] <= cap_mode_reg;
            rdata_reg[svc_pkg::FAN_MODE_LSB +: svc_pkg::MODE_W] <= fan_mode_reg;
          end
          svc_pkg::OFS_CAP_PCT: begin
            rdata_reg[svc_pkg::PCT_W-1:0] <= cap_w.percent;
          end
          svc_pkg::OFS_FAN_PCT: begin
            rdata_reg[svc_pkg::PCT_W-1:0] <= fan_w.percent;
          end
          svc_pkg::OFS_NOTE: begin
            rdata_reg[svc_pkg::NOTE_W-1:0] <= note_reg;
          end
          svc_pkg::OFS_STATUS: begin
            rdata_reg[svc_pkg::ST_CAP_EXP] <= cap_w.expired;
            rdata_reg[svc_pkg::ST_FAN_EXP] <= fan_w.expired;
            rdata_reg[svc_pkg::ST_CAP_WARN] <= cap_warn_reg;
            rdata_reg[svc_pkg::ST_FAN_WARN] <= fan_warn_reg;
          end
          default: begin
            rdata_reg <= svc_pkg::RDATA_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // maintenance notice
  // ----------------------------------------
  // mode 0 gives no notice
  always_comb begin
    note_next = svc_pkg::NOTE_NONE;
    if (cap_w.expired && notice_on(cap_mode_reg)) begin
      note_next = svc_pkg::NOTE_CAP;
    end else if (fan_w.expired && notice_on(fan_mode_reg)) begin
      note_next = svc_pkg::NOTE_FAN;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      note_reg <= svc_pkg::NOTE_NONE;
    end else if (ce_in) begin
      note_reg <= note_next;
    end
  end

  // ----------------------------------------
  // warnings
  // ----------------------------------------
  // capacitor warning only in mode 2
  assign cap_warn_next = cap_w.expired && alarm_on(cap_mode_reg);
  assign fan_warn_next = fan_w.expired && alarm_on(fan_mode_reg);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cap_warn_reg <= 1'h0;
      fan_warn_reg <= 1'h0;
    end else if (ce_in) begin
      cap_warn_reg <= cap_warn_next;
      fan_warn_reg <= fan_warn_next;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      msg_reg <= 1'h0;
      panel_reg <= 1'h0;
    end else if (ce_in) begin
      msg_reg <= (cap_warn_next && !cap_warn_reg) || (fan_warn_next && !fan_warn_reg);
      panel_reg <= cap_warn_next || fan_warn_next;
    end
  end

  assign capacitor_expiry_warning_out = cap_warn_reg;
  assign fan_expiry_warning_out = fan_warn_reg;
  assign warning_msg_out = msg_reg;
  assign panel_warning_out = panel_reg;
  assign maintenance_note_out = note_reg;
  assign rdata_out = rdata_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_cap_restore_full: assert property (
    ce_in && cap_w.restore |=> cap_w.percent == svc_pkg::PCT_FULL
  ) else $error("capacitor percent not restored");

  a_fan_restore_full: assert property (
    ce_in && fan_w.restore |=> fan_w.percent == svc_pkg::PCT_FULL
  ) else $error("fan percent not restored");

  a_sel_zero_noop: assert property (
    ce_in && sel_write && wdata_in == svc_pkg::SEL_NONE
    |=> cap_w.percent <= $past(cap_w.percent) && fan_w.percent <= $past(fan_w.percent)
  ) else $error("selector zero changed a percent");

  a_cap_off_hold: assert property (
    ce_in && !inverter_running_in && !cap_w.restore |=> $stable(cap_w.percent)
  ) else $error("capacitor aged while inverter off");

  a_fan_stop_hold: assert property (
    ce_in && !fan_running_in && !fan_w.restore |=> $stable(fan_w.percent)
  ) else $error("fan aged while not running");

  a_cap_expiry_kept: assert property (
    ce_in && cap_w.expired && !cap_w.restore |=> cap_w.expired
  ) else $error("capacitor expiry dropped without restore");

  a_cap_warn_mode: assert property (
    $past(ce_in) && $past(cap_mode_reg) != svc_pkg::MODE_ALARM |-> !cap_warn_reg
  ) else $error("capacitor warning outside mode 2");

  a_warn_level_hold: assert property (
    ce_in && cap_w.expired && alarm_on(cap_mode_reg) && !cap_w.restore
    ##1 ce_in && $stable(cap_mode_reg) && !cap_w.restore
    && !(wr_in && addr_in == svc_pkg::OFS_MODE) |=> cap_warn_reg [*2]
  ) else $error("capacitor warning not held");

  a_note_idle_code: assert property (
    $past(ce_in) && !$past(cap_w.expired) && !$past(fan_w.expired)
    |-> note_reg == svc_pkg::NOTE_NONE
  ) else $error("notice not idle code");

  a_note_cap_code: assert property (
    $past(ce_in) && $past(cap_w.expired) && notice_on($past(cap_mode_reg))
    |-> note_reg == svc_pkg::NOTE_CAP
  ) else $error("capacitor notice code missing");

  a_note_fan_code: assert property (
    $past(ce_in) && $past(fan_w.expired) && notice_on($past(fan_mode_reg))
    && !$past(cap_w.expired) |-> note_reg == svc_pkg::NOTE_FAN
  ) else $error("fan notice code missing");

  a_mode_zero_quiet: assert property (
    $past(ce_in) && $past(cap_mode_reg) == svc_pkg::MODE_NONE
    && $past(fan_mode_reg) == svc_pkg::MODE_NONE
    |-> note_reg == svc_pkg::NOTE_NONE && !panel_reg && !msg_reg
  ) else $error("mode zero raised a notice");

  a_alarm_msg_pulse: assert property (
    ce_in && fan_w.expired && alarm_on(fan_mode_reg) && !fan_warn_reg && !fan_w.restore
    |=> msg_reg && panel_reg && fan_warn_reg
  ) else $error("alarm message not raised");

  a_fan_expiry_kept: assert property (
    ce_in && fan_w.expired && !fan_w.restore |=> fan_w.expired
  ) else $error("fan expiry dropped without restore");

  a_fan_warn_mode: assert property (
    $past(ce_in) && $past(fan_mode_reg) != svc_pkg::MODE_ALARM |-> !fan_warn_reg
  ) else $error("fan warning outside mode 2");

  a_fan_level_hold: assert property (
    ce_in && fan_w.expired && alarm_on(fan_mode_reg) && !fan_w.restore
    ##1 ce_in && $stable(fan_mode_reg) && !fan_w.restore
    && !(wr_in && addr_in == svc_pkg::OFS_MODE) |=> fan_warn_reg [*2]
  ) else $error("fan warning not held");

  a_cap_alarm_pulse: assert property (
    ce_in && cap_w.expired && alarm_on(cap_mode_reg) && !cap_warn_reg
    |=> msg_reg && panel_reg && cap_warn_reg
  ) else $error("capacitor alarm message not raised");

  a_panel_level: assert property (
    $past(ce_in) |-> panel_reg == (cap_warn_reg || fan_warn_reg)
  ) else $error("panel warning not level of warnings");

  a_msg_on_rise: assert property (
    $past(ce_in)
    |-> msg_reg == ($rose(cap_warn_reg) || $rose(fan_warn_reg))
  ) else $error("message pulse not on warning rise");

  a_ce_freeze: assert property (
    !ce_in
    |=> $stable(cap_mode_reg) && $stable(note_reg) && $stable(cap_w.percent)
  ) else $error("state moved while clock enable low");

  a_read_one_cycle: assert property (
    ce_in && !rd_in |=> rdata_reg == svc_pkg::RDATA_IDLE
  ) else $error("read data outside answer cycle");

  localparam logic [svc_pkg::PCT_W-1:0] PCT_ONE_C = svc_pkg::PCT_STEP;

  c_cap_expires: cover property (ce_in && cap_w.percent == PCT_ONE_C ##1 cap_w.expired);
  c_fan_warns: cover property ($rose(fan_warn_reg));
  c_restore_after: cover property (cap_w.expired ##1 ce_in && cap_w.restore);
  c_both_expired: cover property (cap_w.expired && fan_w.expired);
  c_msg_pulse: cover property (msg_reg ##1 !msg_reg);
endmodule : service_interval_monitor

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk_in = 1'h0;
  logic nrst_in = 1'h0;
  logic ce_in = 1'h1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'h0;
  logic rd_in = 1'h0;
  logic [31:0] rdata_out;
  logic [7:0] cap_temp_in = 8'h00;
  logic inverter_running_in = 1'h0;
  logic [7:0] fan_speed_in = 8'h00;
  logic fan_running_in = 1'h0;
  logic cap_warn;
  logic fan_warn;
  logic msg;
  logic panel;
  logic [15:0] note;
  int failures = 0;
  int checks = 0;
  int msgs = 0;
  logic [31:0] rv;
  int d1;
  int d2;
  logic [7:0] ofs [8] = '{svc_pkg::OFS_MODE, svc_pkg::OFS_RESET_SEL, svc_pkg::OFS_CAP_PCT,
    svc_pkg::OFS_FAN_PCT, svc_pkg::OFS_NOTE, svc_pkg::OFS_STATUS, 8'h18, 8'hfc};
  logic [31:0] rst [8] = '{32'h0000_0011, 32'h0, 32'h0000_0064, 32'h0000_0064, 32'h0, 32'h0,
    32'h0, 32'h0};

  // ----------------------------------------
  // clock, dut, pulse counter
  // ----------------------------------------
  always #12.5 clk_in = ~clk_in;

  service_interval_monitor #(
    .CAP_WEAR_PER_PCT(4),
    .FAN_WEAR_PER_PCT(4)
  ) i_dut (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .cap_temp_in(cap_temp_in),
    .inverter_running_in(inverter_running_in),
    .fan_speed_in(fan_speed_in),
    .fan_running_in(fan_running_in),
    .capacitor_expiry_warning_out(cap_warn),
    .fan_expiry_warning_out(fan_warn),
    .warning_msg_out(msg),
    .panel_warning_out(panel),
    .maintenance_note_out(note)
  );

  always @(posedge clk_in) begin
    if (msg === 1'h1) msgs++;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge clk_in);
    wr_in <= 1'h0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1 d = rdata_out;
  endtask : rd

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rv);
    chk(rv, exp);
  endtask : rchk

  task age(input bit cap, input logic [7:0] v, input int n);
    @(posedge clk_in);
    if (cap) begin
      cap_temp_in <= v;
      inverter_running_in <= 1'h1;
    end else begin
      fan_speed_in <= v;
      fan_running_in <= 1'h1;
    end
    repeat (n) @(posedge clk_in);
    inverter_running_in <= 1'h0;
    fan_running_in <= 1'h0;
  endtask : age

  task outs(input bit cap, input bit w2, input logic [15:0] n);
    chk({29'h0, cap_warn, fan_warn, panel}, {29'h0, cap & w2, !cap & w2, w2});
    chk({16'h0, note}, {16'h0, n});
  endtask : outs

  // run one component to expiry in mode m, then restore it
  task expire(input bit cap, input logic [1:0] m);
    logic [7:0] po;
    logic [31:0] sel;
    int sh;
    logic w2;
    logic [15:0] n;
    po = cap ? svc_pkg::OFS_CAP_PCT : svc_pkg::OFS_FAN_PCT;
    sel = cap ? svc_pkg::SEL_CAP : svc_pkg::SEL_FAN;
    sh = cap ? svc_pkg::CAP_MODE_LSB : svc_pkg::FAN_MODE_LSB;
    w2 = (m == 2'h2);
    n = (m == 2'h1 || w2) ? (cap ? svc_pkg::NOTE_CAP : svc_pkg::NOTE_FAN) : svc_pkg::NOTE_NONE;
    wr(svc_pkg::OFS_MODE, 32'(m) << sh);
    rchk(svc_pkg::OFS_MODE, 32'(m) << sh);
    wr(svc_pkg::OFS_RESET_SEL, sel);
    rchk(po, 32'(svc_pkg::PCT_FULL));
    #1 msgs = 0;
    age(cap, 8'h04, 160);
    repeat (3) @(posedge clk_in);
    rchk(po, 32'(svc_pkg::PCT_EMPTY));
    rchk(svc_pkg::OFS_NOTE, 32'(n));
    rchk(svc_pkg::OFS_STATUS, {28'h0, !cap & w2, cap & w2, !cap, cap});
    outs(cap, w2, n);
    chk(32'(msgs), 32'(w2));
    age(cap, 8'h04, 20);
    rchk(po, 32'(svc_pkg::PCT_EMPTY));
    outs(cap, w2, n);
    wr(svc_pkg::OFS_RESET_SEL, sel);
    rchk(po, 32'(svc_pkg::PCT_FULL));
    rchk(svc_pkg::OFS_STATUS, 32'h0);
    outs(cap, 1'h0, svc_pkg::NOTE_NONE);
  endtask : expire

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    repeat (30000) @(posedge clk_in);
    failures++;
    $display("timeout at %0t", $time);
    results;
  end

  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'h1;
    for (int i = 0; i < 8; i++) rchk(ofs[i], rst[i]);
    outs(1'h1, 1'h0, svc_pkg::NOTE_NONE);
    @(posedge clk_in);
    cap_temp_in <= 8'h10;
    fan_speed_in <= 8'h10;
    repeat (40) @(posedge clk_in);
    age(1'h0, 8'h00, 40);
    rchk(svc_pkg::OFS_CAP_PCT, 32'(svc_pkg::PCT_FULL));
    rchk(svc_pkg::OFS_FAN_PCT, 32'(svc_pkg::PCT_FULL));
    age(1'h1, 8'h02, 20);
    rd(svc_pkg::OFS_CAP_PCT, rv);
    d1 = int'(svc_pkg::PCT_FULL) - int'(rv);
    wr(svc_pkg::OFS_RESET_SEL, svc_pkg::SEL_CAP);
    rchk(svc_pkg::OFS_CAP_PCT, 32'(svc_pkg::PCT_FULL));
    age(1'h1, 8'h04, 20);
    rd(svc_pkg::OFS_CAP_PCT, rv);
    d2 = int'(svc_pkg::PCT_FULL) - int'(rv);
    chk(32'(d2 > d1 && d1 > 0), 32'h1);
    rchk(svc_pkg::OFS_NOTE, 32'h0);
    wr(svc_pkg::OFS_RESET_SEL, svc_pkg::SEL_NONE);
    wr(svc_pkg::OFS_RESET_SEL, svc_pkg::SEL_FAN);
    wr(svc_pkg::OFS_RESET_SEL, 32'h0000_0003);
    rchk(svc_pkg::OFS_CAP_PCT, 32'(int'(svc_pkg::PCT_FULL) - d2));
    @(posedge clk_in);
    ce_in <= 1'h0;
    wr(svc_pkg::OFS_MODE, 32'h0000_0022);
    ce_in <= 1'h1;
    rchk(svc_pkg::OFS_MODE, 32'h0000_0011);
    for (int m = 0; m < 4; m++) begin
      expire(1'h1, 2'(m));
      expire(1'h0, 2'(m));
    end
    results;
  end
endmodule : testbench
